// ==== design/tpc_timer_pair.sv ====
//Contract
//RULE1: timer1 overflow sets control bit 7
//RULE2: acknowledge clears overflow flag after two machine cycles
//RULE3: timer0 overflow sets control bit 5
//RULE4: bit 6 enables timer1, subject to gate
//RULE5: bit 4 enables timer0, subject to gate
//RULE6: detected int1 condition sets control bit 3
//RULE7: bit 2 picks falling edge or low level
//RULE8: detected int0 condition sets control bit 1
//RULE9: bit 0 picks falling edge or low level
//RULE10: timer1 gate needs int1 pin high
//RULE11: timer0 gate needs int0 pin high
//RULE12: mode bit 6 selects timer1 counter operation
//RULE13: mode bit 2 selects timer0 counter operation
//RULE14: mode 00 counts modulo 8192, 5-bit prescaler
//RULE15: mode 01 cascades full 16-bit counter
//RULE16: mode 10 reloads low byte from high
//RULE17: timer1 mode 11 freezes its count
//RULE18: timer0 mode 11 splits into two bytes
//RULE19: split high byte runs on timer1 run
//RULE20: split low byte uses timer0 gate, run
//RULE21: timer operation counts once per machine cycle
//RULE22: counter operation counts sampled pin falls
//RULE23: overflow set beats acknowledge clear
//RULE24: firmware write beats same-cycle hardware update
`timescale 1ns/10ps
`default_nettype none
module tpc_timer_pair
    import tpc_pkg::*;
(
    // clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_arst_n,
    input  wire logic         i_clk_en,
    // special function register access
    input  wire tpc_sfr_req_s i_sfr,
    output logic [7:0]        o_sfr_rdata,
    // cpu interrupt acknowledge
    input  wire logic         i_tf0_ack,
    input  wire logic         i_tf1_ack,
    // pins
    input  wire logic         i_ext_int0_pin,
    input  wire logic         i_ext_int1_pin,
    input  wire logic         i_t0_count_pin,
    input  wire logic         i_t1_count_pin,
    // status
    output tpc_req_s          o_req,
    output logic              o_t0_ovf,
    output logic              o_t1_ovf,
    output tpc_state_e        o_state
);
    tpc_state_e          state_q, state_d;
    tpc_ctrl_s           ctrl_q, ctrl_d;
    tpc_mode_s           mode_q, mode_d;
    logic [7:0]          t0l_q, t0l_d, t0h_q, t0h_d, t1l_q, t1l_d, t1h_q, t1h_d;
    logic                lovf0_q, lovf0_d, lovf1_q, lovf1_d, hovf0_q, hovf0_d;
    logic                t0ovf_q, t0ovf_d, t1ovf_q, t1ovf_d;
    logic [NUM_PINS-1:0] smp_q, smp_d, fall_q, fall_d, pin;
    logic [7:0]          rdata_q, rdata_d;
    logic                s1, s2, s3, s4, s5;
    logic                wr, wr_ctrl, run0, run1, inc0, inc1;
    logic                set0, set1, clr0, clr1;

    tpc_pin_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_clk_en  (i_clk_en),
        .i_pins    ({i_t1_count_pin, i_t0_count_pin, i_ext_int1_pin, i_ext_int0_pin}),
        .o_pins    (pin)
    );

    tpc_ack_delay u_ack0 (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_clk_en  (i_clk_en),
        .i_ack     (i_tf0_ack),
        .o_clr     (clr0)                                              // [RULE2]
    );

    tpc_ack_delay u_ack1 (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_clk_en  (i_clk_en),
        .i_ack     (i_tf1_ack),
        .o_clr     (clr1)                                              // [RULE2]
    );

    // one machine cycle is six states
    always_comb begin
        unique case (state_q)
            ST_S1:   state_d = ST_S2;
            ST_S2:   state_d = ST_S3;
            ST_S3:   state_d = ST_S4;
            ST_S4:   state_d = ST_S5;
            ST_S5:   state_d = ST_S6;
            ST_S6:   state_d = ST_S1;
            default: state_d = ST_S1;
        endcase
    end

    assign s1      = i_clk_en && (state_q == ST_S1);
    assign s2      = i_clk_en && (state_q == ST_S2);
    assign s3      = i_clk_en && (state_q == ST_S3);
    assign s4      = i_clk_en && (state_q == ST_S4);
    assign s5      = i_clk_en && (state_q == ST_S5);
    assign wr      = i_clk_en && i_sfr.wr;
    assign wr_ctrl = wr && (i_sfr.addr == SFR_CTRL);

    assign run0 = ctrl_q.tr0 && (!mode_q.timer0_gate || pin[PIN_INT0]);   // [RULE5] [RULE11] [RULE20]
    assign run1 = ctrl_q.tr1 && (!mode_q.timer1_gate || pin[PIN_INT1]);   // [RULE4] [RULE10]
    // counter operation takes the fall seen in the previous machine cycle
    assign inc0 = run0 && (!mode_q.ct0 || fall_q[PIN_CNT0]);         // [RULE13] [RULE21] [RULE22]
    assign inc1 = run1 && (!mode_q.ct1 || fall_q[PIN_CNT1])          // [RULE12] [RULE21] [RULE22]
                  && (mode_q.m1 != MODE_SPLIT);                      // [RULE17]

    // flag raise strobes: timer0 at S2, timer1 at S4
    always_comb begin
        set0 = 1'b0;
        set1 = 1'b0;
        if (s2) begin
            if (mode_q.m0 == MODE_RELOAD || mode_q.m0 == MODE_SPLIT) begin
                set0 = lovf0_q;                                      // [RULE3] [RULE16] [RULE18]
            end else begin
                set0 = lovf0_q && (&t0h_q);                          // [RULE3] [RULE14] [RULE15]
            end
        end
        if (s4) begin
            if (mode_q.m0 == MODE_SPLIT && hovf0_q) begin
                set1 = 1'b1;                                         // [RULE18]
            end else if (mode_q.m1 == MODE_RELOAD) begin
                set1 = lovf1_q;                                      // [RULE1] [RULE16]
            end else if (mode_q.m1 != MODE_SPLIT) begin
                set1 = lovf1_q && (&t1h_q);                          // [RULE1] [RULE14] [RULE15]
            end
        end
    end

    always_comb begin
        ctrl_d  = ctrl_q;
        mode_d  = mode_q;
        t0l_d   = t0l_q;
        t0h_d   = t0h_q;
        t1l_d   = t1l_q;
        t1h_d   = t1h_q;
        lovf0_d = lovf0_q;
        lovf1_d = lovf1_q;
        hovf0_d = hovf0_q;
        smp_d   = smp_q;
        fall_d  = fall_q;
        t0ovf_d = set0;
        t1ovf_d = set1;
        // timer0 low byte at S1
        if (s1) begin
            lovf0_d = 1'b0;
            if (inc0) begin
                if (mode_q.m0 == MODE_13BIT) begin
                    t0l_d[4:0] = t0l_q[4:0] + 5'h01;                 // [RULE14]
                    lovf0_d    = &t0l_q[4:0];
                end else if (mode_q.m0 == MODE_RELOAD && (&t0l_q)) begin
                    t0l_d   = t0h_q;                                 // [RULE16]
                    lovf0_d = 1'b1;
                end else begin
                    t0l_d   = t0l_q + 8'h01;                         // [RULE15] [RULE20]
                    lovf0_d = &t0l_q;
                end
            end
        end
        // timer0 high byte at S2
        if (s2) begin
            hovf0_d = 1'b0;
            if (mode_q.m0 == MODE_SPLIT) begin
                if (ctrl_q.tr1) begin
                    t0h_d   = t0h_q + 8'h01;                         // [RULE19]
                    hovf0_d = &t0h_q;
                end
            end else if (mode_q.m0 != MODE_RELOAD && lovf0_q) begin
                t0h_d = t0h_q + 8'h01;                               // [RULE14] [RULE15]
            end
        end
        // timer1 low byte at S3
        if (s3) begin
            lovf1_d = 1'b0;
            if (inc1) begin
                if (mode_q.m1 == MODE_13BIT) begin
                    t1l_d[4:0] = t1l_q[4:0] + 5'h01;                 // [RULE14]
                    lovf1_d    = &t1l_q[4:0];
                end else if (mode_q.m1 == MODE_RELOAD && (&t1l_q)) begin
                    t1l_d   = t1h_q;                                 // [RULE16]
                    lovf1_d = 1'b1;
                end else begin
                    t1l_d   = t1l_q + 8'h01;                         // [RULE15]
                    lovf1_d = &t1l_q;
                end
            end
        end
        // timer1 high byte at S4
        if (s4 && lovf1_q && (mode_q.m1 == MODE_13BIT || mode_q.m1 == MODE_16BIT)) begin
            t1h_d = t1h_q + 8'h01;                                   // [RULE15]
        end
        // pins sampled once per machine cycle
        if (s5) begin
            smp_d  = pin;
            fall_d = smp_q & ~pin;                                   // [RULE22]
        end
        // external interrupt events
        if (s1) begin
            if (ctrl_q.it0 ? fall_q[PIN_INT0] : !pin[PIN_INT0]) begin
                ctrl_d.ie0 = 1'b1;                                   // [RULE8] [RULE9]
            end
            if (ctrl_q.it1 ? fall_q[PIN_INT1] : !pin[PIN_INT1]) begin
                ctrl_d.ie1 = 1'b1;                                   // [RULE6] [RULE7]
            end
        end
        // a level-mode event drops again once the pin returns high
        if (s2) begin
            if (!ctrl_q.it0 && pin[PIN_INT0]) begin
                ctrl_d.ie0 = 1'b0;                                   // [RULE9]
            end
            if (!ctrl_q.it1 && pin[PIN_INT1]) begin
                ctrl_d.ie1 = 1'b0;                                   // [RULE7]
            end
        end
        if (set0) begin
            ctrl_d.tf0 = 1'b1;                                       // [RULE3] [RULE23]
        end else if (clr0) begin
            ctrl_d.tf0 = 1'b0;                                       // [RULE2]
        end
        if (set1) begin
            ctrl_d.tf1 = 1'b1;                                       // [RULE1] [RULE23]
        end else if (clr1) begin
            ctrl_d.tf1 = 1'b0;                                       // [RULE2]
        end
        // firmware last so that its value stands at the end of the cycle
        if (wr) begin
            unique case (i_sfr.addr)
                SFR_CTRL: ctrl_d = tpc_ctrl_s'(i_sfr.wdata);         // [RULE24] [RULE4] [RULE5]
                SFR_MODE: mode_d = tpc_mode_s'(i_sfr.wdata);
                SFR_T0L:  t0l_d  = i_sfr.wdata;                      // [RULE24]
                SFR_T1L:  t1l_d  = i_sfr.wdata;                      // [RULE24]
                SFR_T0H:  t0h_d  = i_sfr.wdata;                      // [RULE24]
                SFR_T1H:  t1h_d  = i_sfr.wdata;                      // [RULE24]
                default: ;
            endcase
        end
    end

    // register read, unmapped offsets return zero
    always_comb begin
        rdata_d = rdata_q;
        if (i_clk_en && i_sfr.rd) begin
            unique case (i_sfr.addr)
                SFR_CTRL: rdata_d = ctrl_q;
                SFR_MODE: rdata_d = mode_q;
                SFR_T0L:  rdata_d = t0l_q;
                SFR_T1L:  rdata_d = t1l_q;
                SFR_T0H:  rdata_d = t0h_q;
                SFR_T1H:  rdata_d = t1h_q;
                default:  rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= ST_S1;
            ctrl_q  <= tpc_ctrl_s'(REG_RST);
            mode_q  <= tpc_mode_s'(REG_RST);
            t0l_q   <= REG_RST;
            t0h_q   <= REG_RST;
            t1l_q   <= REG_RST;
            t1h_q   <= REG_RST;
            lovf0_q <= 1'b0;
            lovf1_q <= 1'b0;
            hovf0_q <= 1'b0;
            t0ovf_q <= 1'b0;
            t1ovf_q <= 1'b0;
            smp_q   <= PIN_RST;
            fall_q  <= '0;
            rdata_q <= REG_RST;
        end else if (i_clk_en) begin
            state_q <= state_d;
            ctrl_q  <= ctrl_d;
            mode_q  <= mode_d;
            t0l_q   <= t0l_d;
            t0h_q   <= t0h_d;
            t1l_q   <= t1l_d;
            t1h_q   <= t1h_d;
            lovf0_q <= lovf0_d;
            lovf1_q <= lovf1_d;
            hovf0_q <= hovf0_d;
            t0ovf_q <= t0ovf_d;
            t1ovf_q <= t1ovf_d;
            smp_q   <= smp_d;
            fall_q  <= fall_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_sfr_rdata = rdata_q;
    assign o_req       = '{tf1: ctrl_q.tf1, tf0: ctrl_q.tf0, ie1: ctrl_q.ie1, ie0: ctrl_q.ie0};
    assign o_t0_ovf    = t0ovf_q;
    assign o_t1_ovf    = t1ovf_q;
    assign o_state     = state_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    AST_TF1_SET: assert property (set1 && !wr_ctrl |=> ctrl_q.tf1) // [RULE1]
        else $error("timer1 overflow did not raise its flag");
    AST_TF0_SET: assert property (set0 && !wr_ctrl |=> ctrl_q.tf0) // [RULE3]
        else $error("timer0 overflow did not raise its flag");
    AST_ACK_CLR: assert property (i_clk_en && i_tf0_ack ##1 (!i_tf0_ack && i_clk_en && !set0 && !wr_ctrl) [*8]
        ##1 (!i_tf0_ack && i_clk_en && !set0 && !wr_ctrl) [*4] |=> !ctrl_q.tf0) // [RULE2]
        else $error("timer0 flag not cleared two machine cycles after acknowledge");
    AST_SET_WINS: assert property (clr1 && set1 && !wr_ctrl |=> ctrl_q.tf1) // [RULE23]
        else $error("acknowledge clear beat an overflow set");
    AST_RUN0_OFF: assert property (s1 && !ctrl_q.tr0 && !wr |=> $stable(t0l_q)) // [RULE5]
        else $error("timer0 low byte moved while stopped");
    AST_TIMER0_GATE: assert property (s1 && mode_q.timer0_gate && !pin[PIN_INT0] && !wr |=> $stable(t0l_q)) // [RULE11]
        else $error("gated timer0 counted with its pin low");
    AST_T1_FROZEN: assert property (mode_q.m1 == MODE_SPLIT && !wr |=> $stable(t1l_q) && $stable(t1h_q)) // [RULE17]
        else $error("timer1 moved in the frozen mode");
    AST_RELOAD: assert property (s1 && mode_q.m0 == MODE_RELOAD && inc0 && (&t0l_q) && !wr
        |=> t0l_q == $past(t0h_q)) // [RULE16]
        else $error("low byte not reloaded from high byte");
    AST_TIMER_RATE: assert property (s1 && run0 && !mode_q.ct0 && mode_q.m0 == MODE_16BIT && !wr
        |=> t0l_q == $past(t0l_q) + 8'h01) // [RULE21]
        else $error("timer0 did not count once in the machine cycle");
    AST_FW_WINS: assert property (wr && i_sfr.addr == SFR_T1L |=> t1l_q == $past(i_sfr.wdata)) // [RULE24]
        else $error("firmware write lost to a hardware update");
    AST_IE_LEVEL: assert property (s1 && !ctrl_q.it0 && !pin[PIN_INT0] && !wr_ctrl |=> ctrl_q.ie0) // [RULE8]
        else $error("low level on int0 pin did not raise its event");

    COV_T0_OVF:   cover property (set0);
    COV_SPLIT_T1: cover property (set1 && mode_q.m0 == MODE_SPLIT);
    COV_CLEAR:    cover property (clr0 ##1 !ctrl_q.tf0);
    COV_EDGE_IE1: cover property (s1 && ctrl_q.it1 && fall_q[PIN_INT1]);
endmodule : tpc_timer_pair
`default_nettype wire

// ==== design/tpc_pkg.sv ====
`default_nettype none
package tpc_pkg;

    // special function register offsets
    localparam logic [7:0] SFR_CTRL = 8'h88;
    localparam logic [7:0] SFR_MODE = 8'h89;
    localparam logic [7:0] SFR_T0L  = 8'h8a;
    localparam logic [7:0] SFR_T1L  = 8'h8b;
    localparam logic [7:0] SFR_T0H  = 8'h8c;
    localparam logic [7:0] SFR_T1H  = 8'h8d;

    localparam logic [7:0] REG_RST  = 8'h00;

    // machine cycle and acknowledge timing
    localparam int unsigned STATES_PER_MC = 6;
    localparam int unsigned ACK_MC        = 2;
    localparam int unsigned ACK_CLKS      = ACK_MC * STATES_PER_MC;

    // synchronised pin vector layout; pins idle high
    localparam int unsigned NUM_PINS = 4;
    localparam int unsigned PIN_INT0 = 0;
    localparam int unsigned PIN_INT1 = 1;
    localparam int unsigned PIN_CNT0 = 2;
    localparam int unsigned PIN_CNT1 = 3;
    localparam logic [3:0]  PIN_RST  = 4'hf;

    typedef enum logic [2:0] {
        ST_S1 = 3'b000,
        ST_S2 = 3'b001,
        ST_S3 = 3'b010,
        ST_S4 = 3'b011,
        ST_S5 = 3'b100,
        ST_S6 = 3'b101
    } tpc_state_e;

    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } tpc_mode_e;

    // control register, bit 7 down to bit 0
    typedef struct packed {
        logic tf1;
        logic tr1;
        logic tf0;
        logic tr0;
        logic ie1;
        logic it1;
        logic ie0;
        logic it0;
    } tpc_ctrl_s;

    // mode register, bit 7 down to bit 0
    typedef struct packed {
        logic      timer1_gate;
        logic      ct1;
        tpc_mode_e m1;
        logic      timer0_gate;
        logic      ct0;
        tpc_mode_e m0;
    } tpc_mode_s;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tpc_sfr_req_s;

    typedef struct packed {
        logic tf1;
        logic tf0;
        logic ie1;
        logic ie0;
    } tpc_req_s;

endpackage : tpc_pkg
`default_nettype wire

// ==== design/tpc_pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpc_pin_sync
    import tpc_pkg::*;
(
    // clock and reset
    input  wire logic                i_clk_sys,
    input  wire logic                i_arst_n,
    input  wire logic                i_clk_en,
    // pins
    input  wire logic [NUM_PINS-1:0] i_pins,
    output logic      [NUM_PINS-1:0] o_pins
);
    logic [NUM_PINS-1:0] s1_q, s2_q, s3_q, filt_q;
    logic [NUM_PINS-1:0] filt_d;

    // a level is taken only once the two later stages agree
    always_comb begin
        filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_q   <= PIN_RST;
            s2_q   <= PIN_RST;
            s3_q   <= PIN_RST;
            filt_q <= PIN_RST;
        end else if (i_clk_en) begin
            s1_q   <= i_pins;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= filt_d;
        end
    end

    assign o_pins = filt_q;
endmodule : tpc_pin_sync
`default_nettype wire

// ==== design/tpc_ack_delay.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpc_ack_delay
    import tpc_pkg::*;
(
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_arst_n,
    input  wire logic i_clk_en,
    // acknowledge in, clear strobe out
    input  wire logic i_ack,
    output logic      o_clr
);
    localparam logic [3:0] DLY = 4'(ACK_CLKS);
    logic [3:0] cnt_q, cnt_d;

    // a repeated acknowledge restarts the wait
    always_comb begin
        cnt_d = cnt_q;
        if (i_ack) begin
            cnt_d = DLY;
        end else if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= 4'h0;
        end else if (i_clk_en) begin
            cnt_q <= cnt_d;
        end
    end

    assign o_clr = i_clk_en && !i_ack && (cnt_q == 4'h1);
endmodule : tpc_ack_delay
`default_nettype wire

// ==== testbench/tpc_cpu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpc_cpu_model
    import tpc_pkg::*;
(
    // clock
    input  wire logic       i_clk_sys,
    // register bus
    input  wire logic [7:0] i_sfr_rdata,
    output var tpc_sfr_req_s o_sfr,
    // acknowledges
    output logic            o_tf0_ack,
    output logic            o_tf1_ack
);
    initial begin
        o_sfr     = '0;
        o_tf0_ack = 1'b0;
        o_tf1_ack = 1'b0;
    end

    // released bus shows inverted qualifiers so stale values never match by luck
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_sfr <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge i_clk_sys);
        o_sfr <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clk_sys);
        o_sfr <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge i_clk_sys);
        o_sfr <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        #1;
        v = i_sfr_rdata;
    endtask : sfr_rd

    task automatic ack(input logic sel);
        @(posedge i_clk_sys);
        o_tf0_ack <= ~sel;
        o_tf1_ack <= sel;
        @(posedge i_clk_sys);
        o_tf0_ack <= 1'b0;
        o_tf1_ack <= 1'b0;
    endtask : ack
endmodule : tpc_cpu_model
`default_nettype wire

// ==== testbench/dual_timer_control_mode_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module dual_timer_control_mode_tb
    import tpc_pkg::*;
;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } tpc_row_s;

    logic         clk    = 1'b0;
    logic         arst_n = 1'b0;
    logic [3:0]   pins   = 4'hf; // cnt1, cnt0, int1, int0
    logic [7:0]   rdata;
    tpc_sfr_req_s sfr;
    logic         ack0;
    logic         ack1;
    logic         ovf0;
    logic         ovf1;
    logic         seen0  = 1'b0;
    logic         seen1  = 1'b0;
    tpc_req_s     req;
    tpc_state_e   state;
    int           err_count  = 0;
    int           n_compared = 0;
    logic [7:0]   sa[3];
    logic [7:0]   v;
    tpc_row_s     rows[7];

    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (ovf0) seen0 <= 1'b1;
        if (ovf1) seen1 <= 1'b1;
    end

    tpc_timer_pair dut (
        .i_clk_sys(clk), .i_arst_n(arst_n), .i_clk_en(1'b1), .i_sfr(sfr), .o_sfr_rdata(rdata),
        .i_tf0_ack(ack0), .i_tf1_ack(ack1), .i_ext_int0_pin(pins[0]), .i_ext_int1_pin(pins[1]),
        .i_t0_count_pin(pins[2]), .i_t1_count_pin(pins[3]), .o_req(req), .o_t0_ovf(ovf0),
        .o_t1_ovf(ovf1), .o_state(state)
    );
    tpc_cpu_model cpu (.i_clk_sys(clk), .i_sfr_rdata(rdata), .o_sfr(sfr), .o_tf0_ack(ack0), .o_tf1_ack(ack1));

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
            err_count++;
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        cpu.sfr_rd(a, r);
        chk(e, r);
    endtask : rdc

    task automatic chkq(input logic [7:0] e);
        #1;
        chk(e, {4'h0, req});
    endtask : chkq

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    task automatic setp(input logic [3:0] p);
        @(posedge clk);
        pins <= p;
    endtask : setp

    // bounded wait on one request bit; running out counts as a mismatch
    task automatic waitq(input int idx, input int n);
        int i;
        for (i = 0; i < n && req[idx] !== 1'b1; i++) @(posedge clk);
        if (i == n) begin
            err_count++;
            $display("unexpected at %0t: expected %h got %h", $time, 1'b1, req[idx]);
            results();
        end
    endtask : waitq

    // growth of three byte registers over 72 clocks, i.e. 12 machine cycles
    task automatic span(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
        logic [7:0] v0[3];
        logic [7:0] v1[3];
        logic [7:0] ex[3];
        ex = '{e0, e1, e2};
        for (int i = 0; i < 3; i++) cpu.sfr_rd(sa[i], v0[i]);
        wt(66);
        for (int i = 0; i < 3; i++) cpu.sfr_rd(sa[i], v1[i]);
        for (int i = 0; i < 3; i++) chk(ex[i], 8'(v1[i] - v0[i]));
    endtask : span

    initial begin
        rows = '{'{SFR_CTRL, 8'h05, 8'h05}, '{SFR_MODE, 8'h5a, 8'h5a}, '{SFR_T0L, 8'h10, 8'h10},
                 '{SFR_T1L, 8'h20, 8'h20}, '{SFR_T0H, 8'h30, 8'h30}, '{SFR_T1H, 8'h40, 8'h40},
                 '{8'h90, 8'h55, 8'h00}};
        wt(20);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            rdc(rows[i].a, REG_RST);
            cpu.sfr_wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        cpu.sfr_wr(SFR_MODE, 8'h11);
        cpu.sfr_wr(SFR_CTRL, 8'h50);
        sa = '{SFR_T0L, SFR_T1L, SFR_T0H};
        span(8'h0c, 8'h0c, 8'h00);
        cpu.sfr_wr(SFR_MODE, 8'h99);
        setp(4'hc);
        wt(20);
        chkq(8'h03);
        span(8'h00, 8'h00, 8'h00);
        setp(4'hf);
        wt(20);
        chkq(8'h00);
        span(8'h0c, 8'h0c, 8'h00);
        cpu.sfr_wr(SFR_MODE, 8'h33);
        cpu.sfr_wr(SFR_CTRL, 8'h40);
        sa = '{SFR_T0H, SFR_T0L, SFR_T1L};
        span(8'h0c, 8'h00, 8'h00);
        cpu.sfr_wr(SFR_CTRL, 8'h10);
        span(8'h00, 8'h0c, 8'h00);
        // two machine cycles of run: low five bits wrap, upper bits kept
        cpu.sfr_wr(SFR_CTRL, 8'h00);
        cpu.sfr_wr(SFR_MODE, 8'h00);
        cpu.sfr_wr(SFR_T0L, 8'hff);
        cpu.sfr_wr(SFR_T0H, 8'h05);
        cpu.sfr_wr(SFR_CTRL, 8'h10);
        wt(10);
        cpu.sfr_wr(SFR_CTRL, 8'h00);
        rdc(SFR_T0L, 8'he1);
        rdc(SFR_T0H, 8'h06);
        cpu.sfr_wr(SFR_MODE, 8'h01);
        cpu.sfr_wr(SFR_T0H, 8'hff);
        cpu.sfr_wr(SFR_T0L, 8'hfd);
        cpu.sfr_wr(SFR_CTRL, 8'h10);
        waitq(2, 40);
        cpu.sfr_wr(SFR_CTRL, 8'h20);
        chk(8'h01, {7'h0, seen0});
        rdc(SFR_CTRL, 8'h20);
        cpu.ack(1'b0);
        wt(11);
        chkq(8'h04);
        wt(2);
        chkq(8'h00);
        cpu.sfr_wr(SFR_MODE, 8'h20);
        cpu.sfr_wr(SFR_T1H, 8'hf0);
        cpu.sfr_wr(SFR_T1L, 8'hfd);
        cpu.sfr_wr(SFR_CTRL, 8'h40);
        waitq(3, 40);
        cpu.sfr_wr(SFR_CTRL, 8'h80);
        chk(8'h01, {7'h0, seen1});
        rdc(SFR_T1H, 8'hf0);
        cpu.sfr_rd(SFR_T1L, v);
        chk(8'hf0, v & 8'hf0);
        cpu.ack(1'b1);
        wt(13);
        chkq(8'h00);
        cpu.sfr_wr(SFR_MODE, 8'h55);
        cpu.sfr_wr(SFR_T0L, 8'h00);
        cpu.sfr_wr(SFR_T1L, 8'h00);
        cpu.sfr_wr(SFR_CTRL, 8'h50);
        repeat (3) begin
            setp(4'h3);
            wt(12);
            setp(4'hf);
            wt(12);
        end
        wt(12);
        rdc(SFR_T0L, 8'h03);
        rdc(SFR_T1L, 8'h03);
        cpu.sfr_wr(SFR_CTRL, 8'h05);
        setp(4'hc);
        wt(12);
        setp(4'hf);
        wt(20);
        chkq(8'h03);
        cpu.sfr_wr(SFR_CTRL, 8'h00);
        chkq(8'h00);
        // both timers reload every machine cycle, so the timer1 clear strobe meets a set
        cpu.sfr_wr(SFR_MODE, 8'h22);
        cpu.sfr_wr(SFR_T0H, 8'hff);
        cpu.sfr_wr(SFR_T0L, 8'hff);
        cpu.sfr_wr(SFR_T1H, 8'hff);
        cpu.sfr_wr(SFR_T1L, 8'hff);
        cpu.sfr_wr(SFR_CTRL, 8'h50);
        #1;
        for (int i = 0; i < 6 && state !== ST_S3; i++) begin
            @(posedge clk);
            #1;
        end
        cpu.ack(1'b1);
        wt(12);
        chkq(8'h0c);
        rdc(SFR_T0L, 8'hff);
        // mid-run reset: idle values at once, phase restarts at S1
        @(posedge clk);
        arst_n <= 1'b0;
        wt(3);
        arst_n <= 1'b1;
        chkq(8'h00);
        chk(REG_RST, rdata);
        chk({5'h0, ST_S1}, {5'h0, state});
        wt(1);
        #1;
        chk({5'h0, ST_S2}, {5'h0, state});
        rdc(SFR_CTRL, REG_RST);
        rdc(SFR_MODE, REG_RST);
        results();
    end
endmodule : dual_timer_control_mode_tb
`default_nettype wire
